// ### src/iop_pkg.sv
/*
 io sampling and line passing: register map, reset values, timing.
 assumes a 250 MHz system clock and 32-bit register port words.
*/
package iop_pkg;
	localparam int unsigned CLK_PERIOD_NS = 4;
	localparam int unsigned MS_NS         = 1000000;
	localparam int unsigned MS_CYCLES_DEF = MS_NS / CLK_PERIOD_NS;
	localparam int unsigned TENTH_MS      = 100;
	localparam int unsigned NLINES        = 13;

	localparam logic [7:0] OFF_CTRL    = 8'h00;
	localparam logic [7:0] OFF_PERIOD  = 8'h04;
	localparam logic [7:0] OFF_DHIGH   = 8'h08;
	localparam logic [7:0] OFF_DLOW    = 8'h0c;
	localparam logic [7:0] OFF_WAKE    = 8'h10;
	localparam logic [7:0] OFF_CHGMASK = 8'h14;
	localparam logic [7:0] OFF_SRCADDR = 8'h18;
	localparam logic [7:0] OFF_INCFG   = 8'h1c;
	localparam logic [7:0] OFF_OUTCFG  = 8'h20;
	localparam logic [7:0] OFF_LHOLD0  = 8'h24;
	localparam logic [7:0] OFF_PHOLD   = 8'h58;
	localparam logic [7:0] OFF_PDUTY   = 8'h5c;
	localparam logic [7:0] OFF_IRQSTAT = 8'h60;
	localparam logic [7:0] OFF_IRQEN   = 8'h64;
	localparam logic [7:0] OFF_IRQCLR  = 8'h68;
	localparam logic [7:0] OFF_STATUS  = 8'h6c;

	localparam int unsigned CTRL_IOE_BIT  = 0;
	localparam int unsigned CTRL_API_LSB  = 1;
	localparam int unsigned AIN_LSB       = 16;
	localparam int unsigned DDEF_LSB      = 16;
	localparam int unsigned M1_LSB        = 16;
	localparam int unsigned STAT_SLP_BIT  = 16;
	localparam int unsigned IRQ_SENT      = 0;
	localparam int unsigned IRQ_RXFWD     = 1;
	localparam int unsigned IRQ_REVERT    = 2;

	localparam logic        IOE_RESET = 1'b1;
	localparam logic [15:0] BCAST_SRC = 16'hffff;
	localparam logic [3:0]  NO_HOLD   = 4'hf;
endpackage

// ### src/iop_line_passing.sv
/*
 io sampling and line passing core: periodic and change-driven
 sampling, serial forwarding of received samples, line passing to
 digital and pwm outputs with hold timers, register port, interrupt.
 assumes awake_in, command_mode_in, rx_* and adc values come from
 logic on clk_sys_in; dio_pins_in are raw pins.
*/
// Decided for this implementation: the placing of the registers and the strobed register port.
// Behaviour
// - sample period zero disables periodic sampling entirely.
// - nonzero period: sample and transmit each time that many ms elapse.
// - samples are addressed to the high and low destination words.
// - with api mode zero, received samples are forwarded only when sample output is enabled outside command mode.
// - samples only generated when some pin is digital or analog input.
// - while awake, periodic samples continue past wake time expiry until awake_in falls.
// - edge on any change-masked line sends a sample immediately.
// - change detect only while awake; wakeup gives a sample if periodic.
// - received digital line n drives only output line n.
// - analog channel 0 sets pwm 0 duty, channel 1 sets pwm 1.
// - sample output enable resets to 1; forwards samples unless in command mode.
// - outputs only update from matching source; default no updating.
// - broadcast source address accepts output data from any sender.
// - per line hold timer; zero holds forever, else reverts after tenths.
// - one pwm hold timer; on expiry each pwm reverts to its default.
module iop_line_passing #(
	parameter int unsigned MS_CYCLES = iop_pkg::MS_CYCLES_DEF
) (
	input  wire logic        clk_sys_in,
	input  wire logic        reset_in,
	input  wire logic        clk_en_in,
	input  wire logic [7:0]  reg_addr_in,
	input  wire logic [31:0] reg_wdata_in,
	input  wire logic        reg_wr_in,
	input  wire logic        reg_rd_in,
	output logic      [31:0] reg_rdata_out,
	output logic             irq_out,
	input  wire logic [12:0] dio_pins_in,
	input  wire logic [9:0]  analog_in0_in,
	input  wire logic [9:0]  analog_in1_in,
	input  wire logic        awake_in,
	input  wire logic        command_mode_in,
	output logic             sleep_ready_out,
	output logic             tx_valid_out,
	input  wire logic        tx_ready_in,
	output logic      [63:0] tx_dest_out,
	output logic      [12:0] tx_digital_out,
	output logic      [9:0]  tx_analog0_out,
	output logic      [9:0]  tx_analog1_out,
	input  wire logic        rx_valid_in,
	input  wire logic [15:0] rx_src_in,
	input  wire logic [12:0] rx_dmask_in,
	input  wire logic [12:0] rx_dstate_in,
	input  wire logic [1:0]  rx_amask_in,
	input  wire logic [9:0]  rx_analog0_in,
	input  wire logic [9:0]  rx_analog1_in,
	output logic             ser_fwd_out,
	output logic      [12:0] dout_out,
	output logic             analog_out0_out,
	output logic             analog_out1_out
);
	import iop_pkg::*;

	typedef struct packed {
		logic             ioe;
		logic [1:0]       api;
		logic [15:0]      period;
		logic [31:0]      dhigh;
		logic [31:0]      dlow;
		logic [15:0]      wake;
		logic [12:0]      chgmask;
		logic [15:0]      srcaddr;
		logic             src_set;
		logic [12:0]      din;
		logic [1:0]       ain;
		logic [12:0]      dmask;
		logic [12:0]      ddef;
		logic [12:0][15:0] lhold;
		logic [12:0][15:0] lcnt;
		logic [7:0]       phold;
		logic [7:0]       pcnt;
		logic [9:0]       m0;
		logic [9:0]       m1;
		logic [2:0]       ist;
		logic [2:0]       ien;
		logic [17:0]      mscnt;
		logic [6:0]       tcnt;
		logic [15:0]      percnt;
		logic [15:0]      wcnt;
		logic [12:0]      s1;
		logic [12:0]      s2;
		logic [12:0]      s3;
		logic [2:0]       prime;
		logic             awk;
		logic             pend;
		logic             txv;
		logic [63:0]      tdst;
		logic [12:0]      tdig;
		logic [9:0]       ta0;
		logic [9:0]       ta1;
		logic [12:0]      dout;
		logic [9:0]       duty0;
		logic [9:0]       duty1;
		logic [9:0]       pwc;
		logic             pw0;
		logic             pw1;
		logic             fwd;
		logic [31:0]      rdata;
	} iop_state_t;

	iop_state_t st;
	iop_state_t next_st;

	logic        ms_tick;
	logic        tenth_tick;
	logic        per_req;
	logic        chg_req;
	logic        wake_req;
	logic        in_any;
	logic        accept;
	logic [12:0] upd_mask;
	logic [2:0]  ev;

	// decode shared by write and read paths
	function automatic logic [3:0] hold_idx(input logic [7:0] a);
		logic [7:0] d;
		d = a - OFF_LHOLD0;
		if (a >= OFF_LHOLD0 && d[1:0] == 2'b00 && d[7:2] < 6'(NLINES))
			hold_idx = d[5:2];
		else
			hold_idx = NO_HOLD;
	endfunction

	always_comb begin
		logic [3:0] hi;
		hi = hold_idx(reg_addr_in);
		next_st = st;
		ev = '0;

		// time base: ms tick, tenth-second tick
		ms_tick = (32'(st.mscnt) == MS_CYCLES - 1);
		next_st.mscnt = ms_tick ? '0 : st.mscnt + 18'd1;
		tenth_tick = ms_tick && (32'(st.tcnt) == TENTH_MS - 1);
		if (ms_tick)
			next_st.tcnt = tenth_tick ? '0 : st.tcnt + 7'd1;

		// pin synchroniser; edges seen between the second and third stages only
		next_st.s1 = dio_pins_in;
		next_st.s2 = st.s1;
		next_st.s3 = st.s2;
		next_st.awk = awake_in;
		next_st.prime = {st.prime[1:0], 1'b1};

		in_any = (st.din != '0) || (st.ain != '0);

		// periodic sampling only while awake; a sleeping part has no clock
		// budget to spend, and awake_in going low, not the wake window, bounds the sample burst
		per_req = 1'b0;
		if (st.period == '0 || !awake_in) begin
			next_st.percnt = '0;
		end else if (ms_tick) begin
			if (st.percnt + 16'd1 >= st.period) begin
				next_st.percnt = '0;
				per_req = 1'b1;
			end else begin
				next_st.percnt = st.percnt + 16'd1;
			end
		end

		// change detect gated by awake: transitions while asleep are lost
		// sync stages fill after reset; a pin idling high is no edge
		chg_req = awake_in && st.prime[2]
			&& (((st.s2 ^ st.s3) & st.chgmask) != '0);
		wake_req = awake_in && !st.awk && (st.period != '0);

		// wake window timer
		if (awake_in && !st.awk)
			next_st.wcnt = '0;
		else if (awake_in && ms_tick && st.wcnt != 16'hffff)
			next_st.wcnt = st.wcnt + 16'd1;

		if ((per_req || chg_req || wake_req) && in_any)
			next_st.pend = 1'b1;

		// one sample in flight; later requests merge into pend
		if (st.txv && tx_ready_in) begin
			next_st.txv = 1'b0;
			ev[IRQ_SENT] = 1'b1;
		end
		if (st.pend && !st.txv) begin
			next_st.pend = 1'b0;
			next_st.txv = 1'b1;
			next_st.tdst = {st.dhigh, st.dlow};
			next_st.tdig = st.s2 & st.din;
			next_st.ta0 = st.ain[0] ? analog_in0_in : '0;
			next_st.ta1 = st.ain[1] ? analog_in1_in : '0;
		end

		// serial forwarding of received samples
		next_st.fwd = 1'b0;
		if (rx_valid_in) begin
			if (st.ioe && !command_mode_in)
				next_st.fwd = 1'b1;
			else if (st.api != '0)
				next_st.fwd = 1'b1;
		end
		if (next_st.fwd)
			ev[IRQ_RXFWD] = 1'b1;

		// source filter; nothing binds until software sets the address
		accept = rx_valid_in && st.src_set
			&& (st.srcaddr == BCAST_SRC || rx_src_in == st.srcaddr);
		upd_mask = accept ? (rx_dmask_in & st.dmask) : '0;

		for (int n = 0; n < NLINES; n++) begin
			if (upd_mask[n]) begin
				next_st.dout[n] = rx_dstate_in[n];
				next_st.lcnt[n] = st.lhold[n];
			end else if (tenth_tick && st.lcnt[n] != '0) begin
				next_st.lcnt[n] = st.lcnt[n] - 16'd1;
				if (st.lcnt[n] == 16'd1) begin
					next_st.dout[n] = st.ddef[n];
					ev[IRQ_REVERT] = 1'b1;
				end
			end
		end

		if (accept && rx_amask_in != '0) begin
			if (rx_amask_in[0])
				next_st.duty0 = rx_analog0_in;
			if (rx_amask_in[1])
				next_st.duty1 = rx_analog1_in;
			next_st.pcnt = st.phold;
		end else if (tenth_tick && st.pcnt != '0) begin
			next_st.pcnt = st.pcnt - 8'd1;
			if (st.pcnt == 8'd1) begin
				next_st.duty0 = st.m0;
				next_st.duty1 = st.m1;
				ev[IRQ_REVERT] = 1'b1;
			end
		end

		// pwm carriers, 10-bit free running
		next_st.pwc = st.pwc + 10'd1;
		next_st.pw0 = st.pwc < st.duty0;
		next_st.pw1 = st.pwc < st.duty1;

		// register writes
		if (reg_wr_in) begin
			case (reg_addr_in)
				OFF_CTRL: begin
					next_st.ioe = reg_wdata_in[CTRL_IOE_BIT];
					next_st.api = reg_wdata_in[CTRL_API_LSB +: 2];
				end
				OFF_PERIOD:  next_st.period = reg_wdata_in[15:0];
				OFF_DHIGH:   next_st.dhigh = reg_wdata_in;
				OFF_DLOW:    next_st.dlow = reg_wdata_in;
				OFF_WAKE:    next_st.wake = reg_wdata_in[15:0];
				OFF_CHGMASK: next_st.chgmask = reg_wdata_in[12:0];
				OFF_SRCADDR: begin
					next_st.srcaddr = reg_wdata_in[15:0];
					next_st.src_set = 1'b1;
				end
				OFF_INCFG: begin
					next_st.din = reg_wdata_in[12:0];
					next_st.ain = reg_wdata_in[AIN_LSB +: 2];
				end
				OFF_OUTCFG: begin
					next_st.dmask = reg_wdata_in[12:0];
					next_st.ddef = reg_wdata_in[DDEF_LSB +: 13];
				end
				OFF_PHOLD: next_st.phold = reg_wdata_in[7:0];
				OFF_PDUTY: begin
					next_st.m0 = reg_wdata_in[9:0];
					next_st.m1 = reg_wdata_in[M1_LSB +: 10];
				end
				OFF_IRQEN: next_st.ien = reg_wdata_in[2:0];
				default: begin
					if (hi != NO_HOLD)
						next_st.lhold[hi] = reg_wdata_in[15:0];
				end
			endcase
		end

		// sticky status: a same-cycle event beats the clear
		if (reg_wr_in && reg_addr_in == OFF_IRQCLR)
			next_st.ist = st.ist & ~reg_wdata_in[2:0];
		next_st.ist = next_st.ist | ev;

		// read data, valid the cycle after the strobe only
		next_st.rdata = '0;
		if (reg_rd_in) begin
			case (reg_addr_in)
				OFF_CTRL:    next_st.rdata = {29'd0, st.api, st.ioe};
				OFF_PERIOD:  next_st.rdata = {16'd0, st.period};
				OFF_DHIGH:   next_st.rdata = st.dhigh;
				OFF_DLOW:    next_st.rdata = st.dlow;
				OFF_WAKE:    next_st.rdata = {16'd0, st.wake};
				OFF_CHGMASK: next_st.rdata = {19'd0, st.chgmask};
				OFF_SRCADDR: next_st.rdata = {16'd0, st.srcaddr};
				OFF_INCFG:   next_st.rdata = {14'd0, st.ain, 3'd0, st.din};
				OFF_OUTCFG:  next_st.rdata = {3'd0, st.ddef, 3'd0, st.dmask};
				OFF_PHOLD:   next_st.rdata = {24'd0, st.phold};
				OFF_PDUTY:   next_st.rdata = {6'd0, st.m1, 6'd0, st.m0};
				OFF_IRQSTAT: next_st.rdata = {29'd0, st.ist};
				OFF_IRQEN:   next_st.rdata = {29'd0, st.ien};
				OFF_STATUS:  next_st.rdata = {15'd0, sleep_ready_out, 3'd0, st.dout};
				default: begin
					if (hi != NO_HOLD)
						next_st.rdata = {16'd0, st.lhold[hi]};
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			st <= '0;
			st.ioe <= IOE_RESET;
		end else if (clk_en_in) begin
			st <= next_st;
		end
	end

	// wake window spent: sleep controller may return to sleep
	assign sleep_ready_out = awake_in && st.awk && (st.wcnt >= st.wake);
	assign reg_rdata_out   = st.rdata;
	assign irq_out         = (st.ist & st.ien) != '0;
	assign tx_valid_out    = st.txv;
	assign tx_dest_out     = st.tdst;
	assign tx_digital_out  = st.tdig;
	assign tx_analog0_out  = st.ta0;
	assign tx_analog1_out  = st.ta1;
	assign ser_fwd_out     = st.fwd;
	assign dout_out        = st.dout;
	assign analog_out0_out = st.pw0;
	assign analog_out1_out = st.pw1;

	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (reset_in);

	a_period_zero_idle: assert property (st.period == '0 |-> !per_req)
		else $error("periodic request with zero period");
	a_period_fires: assert property (clk_en_in && per_req && in_any && !st.pend
		&& !st.txv |=> st.pend ##1 (st.txv || !clk_en_in))
		else $error("periodic request did not launch a sample");
	a_tx_dest_word: assert property ($rose(tx_valid_out)
		|-> tx_dest_out == {$past(st.dhigh), $past(st.dlow)})
		else $error("sample destination mismatch");
	a_rx_api_drop: assert property (clk_en_in && rx_valid_in && st.api == '0
		&& !(st.ioe && !command_mode_in) |=> !ser_fwd_out)
		else $error("sample forwarded in transparent mode");
	a_need_inputs: assert property ($rose(st.pend) |-> $past(in_any))
		else $error("sample raised with no input configured");
	a_change_sends: assert property (clk_en_in && chg_req && in_any |=> st.pend || st.txv)
		else $error("change edge produced no sample");
	a_asleep_quiet: assert property (!awake_in |-> !chg_req && !per_req)
		else $error("sample requested while asleep");
	a_line_pairs: assert property (clk_en_in && accept
		|=> ((dout_out ^ $past(rx_dstate_in)) & $past(upd_mask)) == '0)
		else $error("digital line not passed to matching output");
	a_pwm_pass: assert property (clk_en_in && accept && rx_amask_in[0]
		|=> st.duty0 == $past(rx_analog0_in))
		else $error("pwm 0 duty not taken from channel 0");
	a_ser_forward: assert property (clk_en_in && rx_valid_in && st.ioe && !command_mode_in
		|=> ser_fwd_out)
		else $error("sample not forwarded to serial");
	a_src_filter: assert property (clk_en_in && rx_valid_in && !accept && !tenth_tick
		|=> $stable(dout_out))
		else $error("outputs changed by foreign source");
	a_bcast_any: assert property (rx_valid_in && st.src_set && st.srcaddr == BCAST_SRC
		|-> accept)
		else $error("broadcast source address rejected data");
	a_hold_restart: assert property (clk_en_in && upd_mask[0]
		|=> st.lcnt[0] == $past(st.lhold[0]))
		else $error("hold timer not restarted by fresh data");
	a_pwm_revert: assert property (clk_en_in && tenth_tick && st.pcnt == 8'd1 && !accept
		|=> st.duty0 == $past(st.m0) && st.duty1 == $past(st.m1))
		else $error("pwm did not revert to default duty");
endmodule

// ### bench/iop_far_end.sv
/*
 far side model: remote module taking our samples and sending its own.
 assumes the bench holds reset_in on clk_sys_in and calls send() from one process.
*/
module iop_far_end (
	input  wire logic        clk_sys_in,
	input  wire logic        reset_in,
	input  wire logic [3:0]  stall_in,
	input  wire logic        tx_valid_in,
	output logic             tx_ready_out,
	output logic      [15:0] accepted_out,
	output logic             rx_valid_out,
	output logic      [15:0] rx_src_out,
	output logic      [12:0] rx_dmask_out,
	output logic      [12:0] rx_dstate_out,
	output logic      [1:0]  rx_amask_out,
	output logic      [9:0]  rx_analog0_out,
	output logic      [9:0]  rx_analog1_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] waited;
	initial begin
		{rx_valid_out, rx_src_out, rx_dmask_out, rx_dstate_out} = '0;
		{rx_amask_out, rx_analog0_out, rx_analog1_out} = '0;
	end
	// slow acceptance on purpose: sample must stand until ready
	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			tx_ready_out <= 1'b0;
			waited <= '0;
			accepted_out <= '0;
		end else if (tx_valid_in && tx_ready_out) begin
			accepted_out <= accepted_out + 16'h1;
			tx_ready_out <= 1'b0;
			waited <= '0;
		end else if (tx_valid_in) begin
			waited <= waited + 4'h1;
			tx_ready_out <= (waited >= stall_in);
		end
	end
	// fields invert after the pulse so stale values never look valid
	task automatic send(input logic [15:0] s, input logic [12:0] m, st,
		input logic [1:0] am, input logic [9:0] a0, a1);
		@(posedge clk_sys_in);
		rx_valid_out <= 1'b1;
		{rx_src_out, rx_dmask_out, rx_dstate_out} <= {s, m, st};
		{rx_amask_out, rx_analog0_out, rx_analog1_out} <= {am, a0, a1};
		@(posedge clk_sys_in);
		rx_valid_out <= 1'b0;
		{rx_src_out, rx_dmask_out, rx_dstate_out} <= ~{s, m, st};
		{rx_amask_out, rx_analog0_out, rx_analog1_out} <= ~{am, a0, a1};
	endtask
endmodule

// ### bench/iop_line_passing_test.sv
/*
 self-checking bench for the sampling and line passing core.
 assumes a 1 ms tick shortened to 10 clocks; far side is iop_far_end.
*/
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin bad_count++; \
	$display("mismatch at %0t: got %0h want %0h", $time, g, e); end end
module iop_line_passing_test;
	timeunit 1ns;
	timeprecision 1ps;
	import iop_pkg::*;
	localparam int MS = 10;
	logic        clk, reset, wr_s, rd_s, awake, cmd, txv, txr, ser, irq, pw0, pw1, got;
	logic        rxv, slp, ce;
	logic [7:0]  addr;
	logic [31:0] wdata, rdata, d, seed, hi, lo;
	logic [12:0] pins, dout, txd, rxm, rxs, exp_dout, m, s;
	logic [9:0]  ain0, ain1, txa0, txa1, rxa0, rxa1;
	logic [63:0] txdest;
	logic [15:0] acc, rxsrc, src;
	logic [1:0]  rxam;
	logic [3:0]  stall;
	int          tests_run, bad_count, cycles, t0, h0, h1;
	iop_line_passing #(.MS_CYCLES(MS)) u_dut (.clk_sys_in(clk), .reset_in(reset),
		.clk_en_in(ce), .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr_s),
		.reg_rd_in(rd_s), .reg_rdata_out(rdata), .irq_out(irq), .dio_pins_in(pins),
		.analog_in0_in(ain0), .analog_in1_in(ain1), .awake_in(awake),
		.command_mode_in(cmd), .sleep_ready_out(slp), .tx_valid_out(txv),
		.tx_ready_in(txr), .tx_dest_out(txdest), .tx_digital_out(txd),
		.tx_analog0_out(txa0), .tx_analog1_out(txa1), .rx_valid_in(rxv),
		.rx_src_in(rxsrc), .rx_dmask_in(rxm), .rx_dstate_in(rxs), .rx_amask_in(rxam),
		.rx_analog0_in(rxa0), .rx_analog1_in(rxa1), .ser_fwd_out(ser), .dout_out(dout),
		.analog_out0_out(pw0), .analog_out1_out(pw1));
	iop_far_end u_far (.clk_sys_in(clk), .reset_in(reset), .stall_in(stall),
		.tx_valid_in(txv), .tx_ready_out(txr), .accepted_out(acc), .rx_valid_out(rxv),
		.rx_src_out(rxsrc), .rx_dmask_out(rxm), .rx_dstate_out(rxs),
		.rx_amask_out(rxam), .rx_analog0_out(rxa0), .rx_analog1_out(rxa1));
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	function automatic logic [12:0] pass(input logic [12:0] cur, mk, st, om);
		return (cur & ~(mk & om)) | (st & mk & om);
	endfunction
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		addr <= a; wdata <= v; wr_s <= 1'b1;
		@(posedge clk);
		wr_s <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge clk);
		addr <= a; rd_s <= 1'b1;
		@(posedge clk);
		rd_s <= 1'b0;
		#1 v = rdata;
	endtask
	task automatic wait_valid(input int n, output logic f);
		f = 1'b0;
		repeat (n) begin
			@(posedge clk);
			#1 if (txv === 1'b1) f = 1'b1;
			if (f) break;
		end
	endtask
	task automatic wait_acc(output int t);
		logic [15:0] a0;
		a0 = acc;
		t = 0;
		while (acc === a0 && t < 400) begin
			@(posedge clk);
			t++;
		end
	endtask
	task automatic pwm_count();
		h0 = 0; h1 = 0;
		repeat (1024) begin
			@(posedge clk);
			#1 h0 += int'(pw0);
			h1 += int'(pw1);
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// ceiling well above the roughly 6300 cycles the sequence needs
	always @(posedge clk) begin
		cycles++;
		if (cycles == 60000) begin
			bad_count++;
			print_verdict();
		end
	end
	initial begin
		{reset, wr_s, rd_s, awake, cmd} = 5'b10010;
		{addr, wdata, pins, ain0, ain1} = '0;
		{tests_run, bad_count, cycles} = '0;
		seed = 32'h6a89; stall = 4'h2; exp_dout = '0;
		ce = 1'b1;
		repeat (6) @(posedge clk);
		reset <= 1'b0;
		rd(OFF_CTRL, d); `CHK(d[0], 1'b1)
		rd(8'h7c, d); `CHK(d, 32'h0)
		wr(OFF_CHGMASK, 32'h8);
		pins <= 13'h8;
		wait_valid(20, got); `CHK(got, 1'b0)
		seed = lfsr(seed); hi = seed; seed = lfsr(seed); lo = seed;
		ain0 <= seed[9:0]; ain1 <= seed[19:10];
		wr(OFF_DHIGH, hi); wr(OFF_DLOW, lo); wr(OFF_CHGMASK, 32'h0);
		wr(OFF_INCFG, 32'h3_1fff);
		wait_valid(300, got); `CHK(got, 1'b0)
		wr(OFF_CHGMASK, 32'h8);
		awake <= 1'b0;
		pins <= 13'h0;
		wait_valid(20, got); `CHK(got, 1'b0)
		awake <= 1'b1;
		repeat (30) @(posedge clk);
		pins <= 13'h1a5c;
		wait_valid(12, got); `CHK(got, 1'b1)
		`CHK(txd, 13'h1a5c)
		`CHK(txdest, {hi, lo})
		`CHK(txa0, ain0)
		`CHK(txa1, ain1)
		wait_acc(t0);
		wr(OFF_CHGMASK, 32'h0);
		wr(OFF_PERIOD, 32'd20);
		wait_acc(t0); wait_acc(t0);
		`CHK(t0 inside {[20*MS-2:20*MS+2]}, 1'b1)
		wr(OFF_PERIOD, 32'd1000);
		wr(OFF_WAKE, 32'd5);
		awake <= 1'b0;
		repeat (10) @(posedge clk);
		awake <= 1'b1;
		wait_valid(10, got); `CHK(got, 1'b1)
		`CHK(slp, 1'b0)
		wait_acc(t0);
		repeat (60) @(posedge clk);
		#1 `CHK(slp, 1'b1)
		wr(OFF_PERIOD, 32'd0);
		wr(OFF_IRQCLR, 32'h7);
		wr(OFF_IRQEN, 32'h2);
		wr(OFF_OUTCFG, 32'h0fff);
		u_far.send(16'h1234, 13'h1fff, 13'h0f0f, 2'b00, 10'h0, 10'h0);
		#1 `CHK(ser, 1'b1)
		`CHK(dout, 13'h0)
		`CHK(irq, 1'b1)
		rd(OFF_IRQSTAT, d); `CHK(d[2:0], 3'b010)
		wr(OFF_IRQCLR, 32'h2);
		#1 `CHK(irq, 1'b0)
		wr(OFF_SRCADDR, 32'h1234);
		for (int i = 0; i < 12; i++) begin
			seed = lfsr(seed);
			if (i == 6) wr(OFF_SRCADDR, {16'h0, BCAST_SRC});
			src = (i % 3 == 2) ? seed[31:16] : 16'h1234;
			m = seed[12:0]; s = seed[25:13];
			if (i >= 6 || src == 16'h1234) exp_dout = pass(exp_dout, m, s, 13'h0fff);
			u_far.send(src, m, s, 2'b00, 10'h0, 10'h0);
			#1 `CHK(dout, exp_dout)
		end
		rd(OFF_STATUS, d); `CHK(d, {15'h0, 1'b1, 3'h0, exp_dout})
		wr(OFF_IRQEN, 32'h0);
		for (int i = 0; i < 16; i++) begin
			cmd <= i[3];
			wr(OFF_CTRL, {29'h0, i[2:0]});
			u_far.send(16'h0001, 13'h0, 13'h0, 2'b00, 10'h0, 10'h0);
			#1 `CHK(ser, (i[0] & ~i[3]) | (i[2:1] != 2'b00))
		end
		`CHK(irq, 1'b0)
		cmd <= 1'b0;
		wr(OFF_CTRL, 32'h1);
		wr(OFF_LHOLD0, 32'h2);
		u_far.send(16'h0002, 13'h0003, 13'h0003, 2'b00, 10'h0, 10'h0);
		exp_dout[1:0] = 2'b11;
		repeat (900) @(posedge clk);
		#1 `CHK(dout, exp_dout)
		repeat (1200) @(posedge clk);
		exp_dout[0] = 1'b0;
		#1 `CHK(dout, exp_dout)
		u_far.send(16'h0002, 13'h0, 13'h0, 2'b11, 10'h100, 10'h300);
		pwm_count();
		`CHK(h0 inside {[255:257]}, 1'b1)
		`CHK(h1 inside {[767:769]}, 1'b1)
		wr(OFF_PDUTY, 32'h0000_0040);
		wr(OFF_PHOLD, 32'h1);
		u_far.send(16'h0002, 13'h0, 13'h0, 2'b11, 10'h100, 10'h300);
		repeat (1100) @(posedge clk);
		pwm_count();
		`CHK(h0 inside {[63:65]}, 1'b1)
		`CHK(h1, 0)
		@(posedge clk) ce <= 1'b0;
		wr(OFF_PDUTY, 32'h0000_03ff);
		ce <= 1'b1;
		rd(OFF_PDUTY, d); `CHK(d, 32'h0000_0040)
		print_verdict();
	end
endmodule
